// File: hw/arb_pkg.sv
package arb_pkg;

  // clocking
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned BUS_CLK_HZ     = 9_500_000;

  // fractional divider for the backplane clock, scaled to keep it narrow
  localparam int unsigned NCO_SCALE      = 100_000;
  localparam int unsigned NCO_W          = 10;
  localparam logic [9:0]  NCO_INC        = 10'(2 * BUS_CLK_HZ / NCO_SCALE);
  localparam logic [9:0]  NCO_MOD        = 10'(CLK_HZ / NCO_SCALE);
  localparam logic [9:0]  NCO_RST        = 10'h000;

  // cycle timeout, in milliseconds and in clk_i cycles
  localparam int unsigned TIMEOUT_MS     = 1;
  localparam int unsigned TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;

  // run of internal cycles after which the bus is offered away
  localparam int unsigned INT_CNT_W      = 3;
  localparam logic [2:0]  INT_CYCLE_LIMIT = 3'h5;
  localparam logic [2:0]  INT_CNT_RST    = 3'h0;

  // synchroniser depths
  localparam int unsigned PIN_SYNC_STAGES  = 3;
  localparam int unsigned XING_SYNC_STAGES = 2;

  // ownership sequencer
  typedef enum {
    ARB_IDLE,
    ARB_ADDR_ON,
    ARB_OWN,
    ARB_CMD_OFF
  } arb_state_t;

endpackage

// File: hw/timeout_if.sv
`timescale 1ns/1ps
`default_nettype none

// retrigger pulse in, expiry level out
interface timeout_if;
  logic trigger;
  logic timeout;
  modport src  (output trigger, input  timeout);
  modport mono (input  trigger, output timeout);
endinterface

`default_nettype wire

// File: hw/sync_chain.sv
`timescale 1ns/1ps
`default_nettype none

module sync_chain #(
  parameter int unsigned STAGES = 2
) (
  // clock and reset of the receiving domain
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // asynchronous level
  input  wire logic d_i,
  // last stage and the one before it
  output logic      q_o,
  output logic      q_prev_o
);

  logic [STAGES-1:0] sr_q;

  // plain shift chain; above two stages only the next stage reads stage zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sr_q <= '0;
    end else begin
      sr_q <= {sr_q[STAGES-2:0], d_i};
    end
  end

  assign q_o      = sr_q[STAGES-1];
  assign q_prev_o = sr_q[STAGES-2];

endmodule

`default_nettype wire

// File: hw/timeout_mono.sv
`timescale 1ns/1ps
`default_nettype none

module timeout_mono #(
  parameter int unsigned CYCLES = arb_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // retrigger and expiry
  timeout_if.mono   to_if
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  logic          armed_q;
  logic          expired_q;

  // retriggerable one-shot; stays expired until the next trigger
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q     <= '0;
      armed_q   <= 1'b0;
      expired_q <= 1'b0;
    end else if (to_if.trigger) begin
      cnt_q     <= '0;
      armed_q   <= 1'b1;
      expired_q <= 1'b0;
    end else if (armed_q && !expired_q) begin
      if (cnt_q == CNT_LAST) begin
        expired_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign to_if.timeout = expired_q;

  // retrigger always quiets the output
  a_retrigger_clears: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    to_if.trigger |=> !to_if.timeout)
    else $error("timeout high right after retrigger");

  // expiry lands exactly one edge after the last count
  a_expiry_exact: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    armed_q && !expired_q && cnt_q == CNT_LAST && !to_if.trigger
    |=> to_if.timeout)
    else $error("timeout did not fire at its count");

  // no early expiry while the count runs
  a_no_early_fire: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(to_if.timeout) |-> $past(cnt_q) == CNT_LAST)
    else $error("timeout fired before its count");

  c_timeout_fired: cover property (
    @(posedge clk_i) disable iff (!reset_n_i) $rose(to_if.timeout));

endmodule

`default_nettype wire

// File: hw/arb_top.sv
// Contract
// - Each bus cycle request restarts a 1 ms watchdog whose output rises if no new request comes in time.
// - The watchdog output ends processor wait states so an access to nothing cannot hang the processor.
// - A low priority-in means a higher master wants the bus, and ownership is given up once the current cycle ends.
// - The ownership request output stays active while this board wants the bus.
// - Priority-out is high only when neither this board nor a higher master requests the bus.
// - The owner holds busy active, which drops only briefly at an exchange or when the bus is idle.
// - All arbitration runs on the shared bus clock, unrelated to other timing.
// - When this board is strapped to source the bus clock it drives it at 9.5 MHz.
// - The board keeps requesting and holds priority-out low except during long runs of internal cycles.
// - Five consecutive internal cycles stop the counter and drop the ownership request unless the processor bus-hold input is low.
// - On gaining ownership, addresses are enabled one bus clock before commands.
// - On release, after the cycle ends, commands go off one bus clock before addresses.
// - While the processor bus-hold input is low, ownership is never released.
// - While a cycle is active with no timeout and no acknowledge, wait states are inserted.
`timescale 1ns/1ps
`default_nettype none

module arb_top #(
  parameter int unsigned TIMEOUT_CYCLES = arb_pkg::TIMEOUT_CYCLES
) (
  // processor clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // processor side, same clock
  input  wire logic cpu_cycle_start_i,
  input  wire logic cpu_cycle_internal_i,
  input  wire logic cpu_bus_hold_n_i,
  input  wire logic bus_cycle_request_n_i,
  output logic      cpu_wait_n_o,
  output logic      bus_timeout_o,
  output logic      bus_owned_o,
  // slave acknowledge from the backplane
  input  wire logic bus_ack_i,
  // bus clock source strap and output
  input  wire logic bus_clk_drive_i,
  output logic      bus_clk_o,
  output logic      bus_clk_oe_o,
  // arbitration, on the shared bus clock
  input  wire logic bus_clk_i,
  input  wire logic prio_in_n_i,
  input  wire logic busy_n_i,
  output logic      busy_n_o,
  output logic      busy_oe_o,
  output logic      bus_ownership_request_out_o,
  output logic      prio_out_o,
  output logic      addr_en_o,
  output logic      cmd_en_o
);

  timeout_if to_if ();

  // ---------------- processor domain ----------------

  logic       req_n_prev_q;
  logic       cycle_active;
  logic [2:0] int_cnt_q;
  logic       int_done;
  logic       want_c;
  logic       ack_s;
  logic       ack_s_prev;
  logic       ack_q;
  logic       strap_s;
  logic       strap_s_prev;
  logic       strap_q;
  logic [9:0] nco_q;
  logic [10:0] nco_sum;
  logic       bus_clk_q;
  logic       owned_s;

  assign cycle_active = !bus_cycle_request_n_i;

  // falling edge of the cycle request retriggers the watchdog
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_n_prev_q <= 1'b1;
    end else begin
      req_n_prev_q <= bus_cycle_request_n_i;
    end
  end

  assign to_if.trigger = req_n_prev_q && !bus_cycle_request_n_i;

  timeout_mono #(
    .CYCLES (TIMEOUT_CYCLES)
  ) u_timeout (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .to_if     (to_if)
  );

  assign bus_timeout_o = to_if.timeout;

  // acknowledge pin: accept a change once the last two stages agree
  sync_chain #(
    .STAGES (arb_pkg::PIN_SYNC_STAGES)
  ) u_ack_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (bus_ack_i),
    .q_o       (ack_s),
    .q_prev_o  (ack_s_prev)
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else if (ack_s == ack_s_prev) begin
      ack_q <= ack_s;
    end
  end

  // wait until acknowledge, or until the watchdog gives up
  assign cpu_wait_n_o = !(cycle_active && !to_if.timeout && !ack_q);

  // run length of internal cycles, saturating at the limit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_cnt_q <= arb_pkg::INT_CNT_RST;
    end else if (cpu_cycle_start_i) begin
      if (!cpu_cycle_internal_i) begin
        int_cnt_q <= arb_pkg::INT_CNT_RST;
      end else if (int_cnt_q != arb_pkg::INT_CYCLE_LIMIT) begin
        int_cnt_q <= int_cnt_q + 3'h1;
      end
    end
  end

  assign int_done = (int_cnt_q == arb_pkg::INT_CYCLE_LIMIT);
  // held bus keeps the request up too, so nobody is invited in
  assign want_c   = !int_done || !cpu_bus_hold_n_i;

  // strap sampled like any pin
  sync_chain #(
    .STAGES (arb_pkg::PIN_SYNC_STAGES)
  ) u_strap_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (bus_clk_drive_i),
    .q_o       (strap_s),
    .q_prev_o  (strap_s_prev)
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_q <= 1'b0;
    end else if (strap_s == strap_s_prev) begin
      strap_q <= strap_s;
    end
  end

  // fractional divider: 9.5 MHz on average, edges jitter by one clk_i
  assign nco_sum = {1'b0, nco_q} + {1'b0, arb_pkg::NCO_INC};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nco_q     <= arb_pkg::NCO_RST;
      bus_clk_q <= 1'b0;
    end else if (nco_sum >= {1'b0, arb_pkg::NCO_MOD}) begin
      nco_q     <= 10'(nco_sum - {1'b0, arb_pkg::NCO_MOD});
      bus_clk_q <= !bus_clk_q;
    end else begin
      nco_q     <= nco_sum[9:0];
    end
  end

  assign bus_clk_o    = bus_clk_q;
  assign bus_clk_oe_o = strap_q;

  // ---------------- bus clock domain ----------------

  logic              bus_rst_q1;
  logic              bus_rst_q2;
  logic              bus_rst_n;
  logic              want_b;
  logic              cycle_b;
  logic              hold_b;
  logic              release_go;
  arb_pkg::arb_state_t state_q;
  logic              addr_en_q;
  logic              cmd_en_q;
  logic              busy_oe_q;

  // reset release retimed to the bus clock
  always_ff @(posedge bus_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_rst_q1 <= 1'b0;
      bus_rst_q2 <= 1'b0;
    end else begin
      bus_rst_q1 <= 1'b1;
      bus_rst_q2 <= bus_rst_q1;
    end
  end

  assign bus_rst_n = bus_rst_q2;

  // processor levels crossing into the bus domain
  sync_chain #(
    .STAGES (arb_pkg::XING_SYNC_STAGES)
  ) u_want_sync (
    .clk_i     (bus_clk_i),
    .reset_n_i (bus_rst_n),
    .d_i       (want_c),
    .q_o       (want_b),
    .q_prev_o  ()
  );

  sync_chain #(
    .STAGES (arb_pkg::XING_SYNC_STAGES)
  ) u_cycle_sync (
    .clk_i     (bus_clk_i),
    .reset_n_i (bus_rst_n),
    .d_i       (cycle_active),
    .q_o       (cycle_b),
    .q_prev_o  ()
  );

  sync_chain #(
    .STAGES (arb_pkg::XING_SYNC_STAGES)
  ) u_hold_sync (
    .clk_i     (bus_clk_i),
    .reset_n_i (bus_rst_n),
    .d_i       (!cpu_bus_hold_n_i),
    .q_o       (hold_b),
    .q_prev_o  ()
  );

  // request and priority chain are pure levels on the bus clock
  assign bus_ownership_request_out_o = want_b;
  assign prio_out_o                  = !want_b && prio_in_n_i;

  // give way only between cycles and never while held
  assign release_go = (!prio_in_n_i || !want_b) && !cycle_b && !hold_b;

  // ownership sequencer
  always_ff @(posedge bus_clk_i or negedge bus_rst_n) begin
    if (!bus_rst_n) begin
      state_q <= arb_pkg::ARB_IDLE;
    end else begin
      case (state_q)
        arb_pkg::ARB_IDLE: begin
          if (want_b && prio_in_n_i && busy_n_i) begin
            state_q <= arb_pkg::ARB_ADDR_ON;
          end
        end
        arb_pkg::ARB_ADDR_ON: begin
          state_q <= arb_pkg::ARB_OWN;
        end
        arb_pkg::ARB_OWN: begin
          if (release_go) begin
            state_q <= arb_pkg::ARB_CMD_OFF;
          end
        end
        arb_pkg::ARB_CMD_OFF: begin
          state_q <= arb_pkg::ARB_IDLE;
        end
        default: begin
          state_q <= arb_pkg::ARB_IDLE;
        end
      endcase
    end
  end

  // driver enables registered from the next state, glitch free
  always_ff @(posedge bus_clk_i or negedge bus_rst_n) begin
    if (!bus_rst_n) begin
      addr_en_q <= 1'b0;
      cmd_en_q  <= 1'b0;
      busy_oe_q <= 1'b0;
    end else begin
      case (state_q)
        arb_pkg::ARB_IDLE: begin
          addr_en_q <= want_b && prio_in_n_i && busy_n_i;
          busy_oe_q <= want_b && prio_in_n_i && busy_n_i;
          cmd_en_q  <= 1'b0;
        end
        arb_pkg::ARB_ADDR_ON: begin
          cmd_en_q  <= 1'b1;
        end
        arb_pkg::ARB_OWN: begin
          cmd_en_q  <= !release_go;
        end
        arb_pkg::ARB_CMD_OFF: begin
          addr_en_q <= 1'b0;
          busy_oe_q <= 1'b0;
        end
        default: begin
          addr_en_q <= 1'b0;
          cmd_en_q  <= 1'b0;
          busy_oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign addr_en_o = addr_en_q;
  assign cmd_en_o  = cmd_en_q;
  assign busy_oe_o = busy_oe_q;
  assign busy_n_o  = 1'b0;

  // ownership back to the processor side
  sync_chain #(
    .STAGES (arb_pkg::XING_SYNC_STAGES)
  ) u_owned_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (cmd_en_q),
    .q_o       (owned_s),
    .q_prev_o  ()
  );

  assign bus_owned_o = owned_s;

  // ---------------- checks ----------------

  a_addr_before_cmd: assert property (
    @(posedge bus_clk_i) disable iff (!bus_rst_n)
    $rose(cmd_en_q) |-> $past(addr_en_q) && $past(addr_en_q, 2) == 1'b0)
    else $error("commands not one clock after addresses");

  a_cmd_before_addr: assert property (
    @(posedge bus_clk_i) disable iff (!bus_rst_n)
    $fell(addr_en_q) |-> !$past(cmd_en_q) && $past(cmd_en_q, 2))
    else $error("addresses not one clock after commands");

  a_hold_keeps_bus: assert property (
    @(posedge bus_clk_i) disable iff (!bus_rst_n)
    cmd_en_q && hold_b |=> cmd_en_q)
    else $error("bus released while held");

  a_release_idle_cycle: assert property (
    @(posedge bus_clk_i) disable iff (!bus_rst_n)
    $fell(cmd_en_q) |-> !$past(cycle_b) && $past(state_q == arb_pkg::ARB_OWN))
    else $error("bus released mid cycle");

  a_busy_while_owned: assert property (
    @(posedge bus_clk_i) disable iff (!bus_rst_n)
    (addr_en_q || cmd_en_q) |-> busy_oe_q)
    else $error("owner not driving busy");

  a_prio_out_excl: assert property (
    @(posedge bus_clk_i) disable iff (!bus_rst_n)
    prio_out_o |-> !bus_ownership_request_out_o && prio_in_n_i)
    else $error("priority passed while requesting");

  a_count_saturates: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    int_done && cpu_cycle_start_i && cpu_cycle_internal_i |=> int_done)
    else $error("internal cycle count moved past limit");

  a_count_clears: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cpu_cycle_start_i && !cpu_cycle_internal_i |=> int_cnt_q == 3'h0)
    else $error("internal cycle count not cleared");

  a_wait_released: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    to_if.timeout |-> cpu_wait_n_o)
    else $error("wait held after timeout");

  a_wait_inserted: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    cycle_active && !to_if.timeout && !ack_q |-> !cpu_wait_n_o)
    else $error("no wait while cycle pending");

  c_bus_gained: cover property (
    @(posedge bus_clk_i) disable iff (!bus_rst_n) $rose(cmd_en_q));

  c_released_prio: cover property (
    @(posedge bus_clk_i) disable iff (!bus_rst_n)
    $fell(cmd_en_q) && !prio_in_n_i);

  c_count_release: cover property (
    @(posedge clk_i) disable iff (!reset_n_i) $rose(int_done));

endmodule

`default_nettype wire

// File: hw/arb_state_alias.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: tb/bus_partner.sv
`timescale 1ns/1ps
`default_nettype none

module bus_partner (
  // processor clock, for the slave side
  input  wire logic       clk_i,
  // bus cycle level from the board, low = active
  input  wire logic       bus_cycle_request_n_i,
  // slave reply delay in clk_i cycles, 0 = no slave present
  input  wire logic [3:0] ack_delay_i,
  // higher master wants the bus, busy wire as resolved
  input  wire logic       hi_want_i,
  input  wire logic       busy_n_i,
  // towards the board
  output logic            bus_clk_o,
  output logic            prio_in_n_o,
  output logic            busy_pull_o,
  output logic            bus_ack_o
);
  int ack_cnt;

  // free running backplane clock, odd start so the phase is unrelated
  initial begin
    bus_clk_o = 1'b0;
    #3.3;
    forever #7.5 bus_clk_o = ~bus_clk_o;
  end

  // higher master asks through the priority chain
  assign prio_in_n_o = ~hi_want_i;

  // takes the bus only when the wire is idle, and only on a bus edge
  initial busy_pull_o = 1'b0;
  always @(posedge bus_clk_o) begin
    if (!hi_want_i)
      busy_pull_o <= 1'b0;
    else if (busy_n_i)
      busy_pull_o <= 1'b1;
  end

  // slave answers after the set delay; a missing slave never answers
  initial begin
    bus_ack_o = 1'b0;
    ack_cnt = 0;
  end
  always @(posedge clk_i) begin
    if (bus_cycle_request_n_i || ack_delay_i == 4'h0) begin
      ack_cnt <= 0;
      bus_ack_o <= 1'b0;
    end else if (ack_cnt >= int'(ack_delay_i)) begin
      bus_ack_o <= 1'b1;
    end else begin
      ack_cnt <= ack_cnt + 1;
    end
  end
endmodule

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define check_eq(nm, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
  end \
end

module testbench;
  // short watchdog so the run stays brief
  localparam int unsigned TO = 40;

  logic       clk_i, reset_n_i, start, internal, hold_n, req_n, strap;
  logic       hi_want, bus_clk, prio_in_n, busy_pull, ack, busy_n_w;
  logic       wait_n, tmo, owned, bclk, bclk_oe, busy_oe, rq_out;
  logic       prio_out, addr_en, cmd_en, pa, pc, pb, busy_dat;
  logic [3:0] ack_dly;
  int         num_errors, total_checks, seed, cnt, k, tog;

  // busy is open drain with a pull-up on the backplane
  assign busy_n_w = ~((busy_oe & ~busy_dat) | busy_pull);

  arb_top #(.TIMEOUT_CYCLES(TO)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .cpu_cycle_start_i(start), .cpu_cycle_internal_i(internal),
    .cpu_bus_hold_n_i(hold_n), .bus_cycle_request_n_i(req_n),
    .cpu_wait_n_o(wait_n), .bus_timeout_o(tmo), .bus_owned_o(owned),
    .bus_ack_i(ack), .bus_clk_drive_i(strap), .bus_clk_o(bclk),
    .bus_clk_oe_o(bclk_oe), .bus_clk_i(bus_clk), .prio_in_n_i(prio_in_n),
    .busy_n_i(busy_n_w), .busy_n_o(busy_dat), .busy_oe_o(busy_oe),
    .bus_ownership_request_out_o(rq_out), .prio_out_o(prio_out),
    .addr_en_o(addr_en), .cmd_en_o(cmd_en)
  );

  bus_partner other (
    .clk_i(clk_i), .bus_cycle_request_n_i(req_n), .ack_delay_i(ack_dly),
    .hi_want_i(hi_want), .busy_n_i(busy_n_w), .bus_clk_o(bus_clk),
    .prio_in_n_o(prio_in_n), .busy_pull_o(busy_pull), .bus_ack_o(ack)
  );

  // processor clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // enable order and priority chain, sampled away from bus edges
  always @(negedge bus_clk) begin
    if (reset_n_i) begin
      if (cmd_en && !pc) `check_eq("addr before cmd", 1'b1, pa)
      if (!addr_en && pa) `check_eq("cmd off first", 1'b0, pc)
      `check_eq("busy with addr", addr_en, busy_oe)
      `check_eq("busy data low", 1'b0, busy_dat)
      `check_eq("prio out", ~rq_out & prio_in_n, prio_out)
    end
    pa <= addr_en;
    pc <= cmd_en;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return rq_out;
      1: return cmd_en;
      2: return addr_en;
      3: return wait_n;
      default: return owned;
    endcase
  endfunction

  // bounded wait; running out of time ends the run
  task automatic wait_for(input int s, input logic v, input string nm);
    int i;
    for (i = 0; i < 60 && pick(s) !== v; i++)
      tick(1);
    `check_eq(nm, v, pick(s))
    if (pick(s) !== v)
      wrap_up();
  endtask

  // one machine cycle, with the reference count kept alongside
  task automatic cpu_cycle(input logic intl);
    start = 1'b1;
    internal = intl;
    tick(1);
    start = 1'b0;
    if (!intl)
      cnt = 0;
    else if (cnt < 5)
      cnt++;
    tick(2);
  endtask

  function automatic logic want_exp();
    return (cnt < 5) || !hold_n;
  endfunction

  // new bus cycle: request goes high one cycle, then falls
  task automatic cyc_begin;
    req_n = 1'b1;
    tick(1);
    req_n = 1'b0;
    tick(1);
  endtask

  initial begin
    seed = 32'h05DC;
    {reset_n_i, start, internal, strap, hi_want, pa, pc} = 7'h00;
    {hold_n, req_n} = 2'h3;
    ack_dly = 4'h0;
    cnt = 0;
    num_errors = 0;
    total_checks = 0;
    tick(12);
    reset_n_i = 1'b1;
    // idle bus is taken, addresses ahead of commands
    wait_for(0, 1'b1, "request out");
    wait_for(1, 1'b1, "cmd enable");
    wait_for(4, 1'b1, "owned");
    // no slave, higher master waiting behind the running cycle
    cyc_begin();
    `check_eq("wait inserted", 1'b0, wait_n)
    // cycle level must cross first, or an idle bus is rightly given up
    tick(2);
    hi_want = 1'b1;
    tick(TO - 3);
    `check_eq("no timeout yet", 1'b0, tmo)
    `check_eq("cycle keeps bus", 1'b1, cmd_en)
    tick(1);
    `check_eq("timeout", 1'b1, tmo)
    `check_eq("wait ended", 1'b1, wait_n)
    cyc_begin();
    tick(1);
    `check_eq("timeout cleared", 1'b0, tmo)
    tick(24);
    cyc_begin();
    tick(TO - 1);
    `check_eq("retriggered", 1'b0, tmo)
    tick(1);
    `check_eq("timeout again", 1'b1, tmo)
    req_n = 1'b1;
    wait_for(1, 1'b0, "cmd released");
    wait_for(2, 1'b0, "addr released");
    tick(20);
    `check_eq("other master owns", 1'b0, addr_en)
    hi_want = 1'b0;
    wait_for(1, 1'b1, "reacquire");
    // a present slave ends the wait before any timeout
    ack_dly = 4'({$random(seed)} % 8 + 1);
    cyc_begin();
    `check_eq("wait before ack", 1'b0, wait_n)
    wait_for(3, 1'b1, "ack ends wait");
    `check_eq("no timeout", 1'b0, tmo)
    req_n = 1'b1;
    ack_dly = 4'h0;
    // four internal cycles keep the bus, the fifth gives it away
    for (k = 0; k < 4; k++)
      cpu_cycle(1'b1);
    tick(10);
    `check_eq("request kept", want_exp(), rq_out)
    cpu_cycle(1'b1);
    wait_for(0, want_exp(), "request dropped");
    wait_for(1, 1'b0, "cmd off");
    wait_for(2, 1'b0, "addr off");
    cpu_cycle(1'b1);
    cpu_cycle(1'b0);
    wait_for(0, want_exp(), "count cleared");
    wait_for(1, 1'b1, "own again");
    k = {$random(seed)} % 5;
    repeat (k) cpu_cycle(1'b1);
    cpu_cycle(1'b0);
    repeat (4) cpu_cycle(1'b1);
    tick(10);
    `check_eq("run broken", want_exp(), rq_out)
    // hold beats both the count and a higher master
    hold_n = 1'b0;
    tick(5);
    cpu_cycle(1'b1);
    hi_want = 1'b1;
    tick(20);
    `check_eq("hold keeps request", want_exp(), rq_out)
    `check_eq("hold keeps bus", 1'b1, cmd_en)
    hold_n = 1'b1;
    wait_for(1, 1'b0, "cmd off after hold");
    wait_for(2, 1'b0, "addr off after hold");
    wait_for(0, want_exp(), "request off");
    hi_want = 1'b0;
    cpu_cycle(1'b0);
    wait_for(1, 1'b1, "final acquire");
    // strapped bus clock: 380 wraps of 500 per 1000 cycles
    strap = 1'b1;
    tick(10);
    `check_eq("clock drive", 1'b1, bclk_oe)
    tog = 0;
    for (k = 0; k < 1000; k++) begin
      pb = bclk;
      tick(1);
      if (bclk !== pb)
        tog++;
    end
    `check_eq("clock rate", 1'b1, tog >= 379 && tog <= 381)
    strap = 1'b0;
    tick(10);
    `check_eq("clock released", 1'b0, bclk_oe)
    wrap_up();
  end
endmodule

`default_nettype wire
